// File: jgp_pkg.sv
// Overview of operation
// - two sticks, each with x and y timing channels, timers and two buttons
// - any write to the port discharges all timing pins and restarts; data ignored
// - the write takes effect on the trailing edge of the write strobe
// - threshold crossing at two thirds reference clears the axis bit and grounds pin
// - byte bits: 0..3 axes s1x s1y s2x s2y, 4..7 buttons s1b1 s1b2 s2b1 s2b2
// - status byte is eight bit read only, live state, never altered by writes
// - status byte reads zero after the standby power on reset
// - host read or write at the programmed base address is a port read or write
// - base address is set by config byte 0x60 high and 0x61 low
// - with the activate bit clear the base address is not decoded at all
// - power control bit 2 and the activate bit mirror each other both ways
package jgp_pkg;
   // status byte location relative to the base address
   localparam logic [15:0] STATUS_OFFSET = 16'h0000;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // status byte field positions
   localparam int BIT_S1X = 0;
   localparam int BIT_S1Y = 1;
   localparam int BIT_S2X = 2;
   localparam int BIT_S2Y = 3;
   localparam int BIT_S1B1 = 4;
   localparam int BIT_S1B2 = 5;
   localparam int BIT_S2B1 = 6;
   localparam int BIT_S2B2 = 7;
   // configuration indices
   localparam logic [7:0] CFG_BASE_HI_IDX = 8'h60;
   localparam logic [7:0] CFG_BASE_LO_IDX = 8'h61;
   localparam logic [7:0] CFG_ACTIVATE_IDX = 8'h30;
   localparam logic [7:0] CFG_PWR_CTL_IDX = 8'h22;
   localparam int ACTIVATE_BIT = 0;
   localparam int PWR_GAME_BIT = 2;
   // configuration reset values
   localparam logic [7:0] BASE_HI_RESET = 8'h00;
   localparam logic [7:0] BASE_LO_RESET = 8'h00;
   localparam logic [7:0] PWR_CTL_RESET = 8'h00;
   localparam logic ACTIVATE_RESET = 1'b0;
   // timing: clock rate and capacitor discharge hold
   localparam int CLK_MHZ = 50;
   localparam int DISCHARGE_NS = 1000;
   localparam int DISCHARGE_CYCLES = (DISCHARGE_NS * CLK_MHZ + 999) / 1000;
endpackage : jgp_pkg

// File: jgp_axis_timer.sv
`timescale 1ns/1ns
`default_nettype none
module jgp_axis_timer #(
   parameter int DISCH_CYCLES = jgp_pkg::DISCHARGE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // restart from the port write
   input wire logic trigger,
   // pad comparator, high at two thirds of reference
   input wire logic threshold_hit,
   // axis bit and open drain timing pin
   output logic axis_bit,
   output logic pin_out,
   output logic pin_oe
);
   localparam int CW = $clog2(DISCH_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(DISCH_CYCLES - 1);

   typedef enum logic [1:0] {
      JGP_IDLE = 2'b00,
      JGP_DISCH = 2'b01,
      JGP_CHARGE = 2'b10
   } jgp_axis_state_type;

   jgp_axis_state_type state_ff;
   logic [CW-1:0] cnt_ff;

   // state: discharge after a write, then charge until threshold
   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= JGP_IDLE;
      end else if (trigger) begin
         state_ff <= JGP_DISCH;
      end else begin
         unique case (state_ff)
            JGP_IDLE: state_ff <= JGP_IDLE;
            JGP_DISCH: if (cnt_ff == '0) state_ff <= JGP_CHARGE;
            JGP_CHARGE: if (threshold_hit) state_ff <= JGP_IDLE;
            default: state_ff <= JGP_IDLE;
         endcase
      end
   end

   // discharge hold counter
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff <= '0;
      end else if (trigger) begin
         cnt_ff <= CNT_LOAD;
      end else if (state_ff == JGP_DISCH && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   // axis bit high from write until threshold
   always_ff @(posedge clk) begin
      if (srst) begin
         axis_bit <= 1'b0;
      end else if (trigger) begin
         axis_bit <= 1'b1;
      end else if (state_ff == JGP_CHARGE && threshold_hit) begin
         axis_bit <= 1'b0;
      end
   end

   // pin grounded except while charging
   assign pin_out = 1'b0;
   assign pin_oe = (state_ff != JGP_CHARGE);

   sequence s_charge_cross;
      state_ff == JGP_CHARGE && threshold_hit && !trigger;
   endsequence

   property p_trig_restart;
      @(posedge clk) disable iff (srst)
      trigger |=> state_ff == JGP_DISCH && axis_bit && pin_oe;
   endproperty
   a_trig_restart: assert property (p_trig_restart) else $error("no restart on trigger");

   property p_cross_ends;
      @(posedge clk) disable iff (srst)
      s_charge_cross |=> !axis_bit && pin_oe && state_ff == JGP_IDLE;
   endproperty
   a_cross_ends: assert property (p_cross_ends) else $error("threshold did not end timing");

   property p_disch_to_charge;
      @(posedge clk) disable iff (srst)
      state_ff == JGP_DISCH && cnt_ff == '0 && !trigger |=> state_ff == JGP_CHARGE && !pin_oe;
   endproperty
   a_disch_to_charge: assert property (p_disch_to_charge) else $error("charge did not start");

   property p_high_while_charging;
      @(posedge clk) disable iff (srst)
      state_ff != JGP_IDLE |-> axis_bit;
   endproperty
   a_high_while_charging: assert property (p_high_while_charging) else $error("axis bit low early");
endmodule : jgp_axis_timer
`default_nettype wire

// File: jgp_game_port.sv
`timescale 1ns/1ns
`default_nettype none
module jgp_game_port #(
   parameter int N_AXES = 4,
   parameter int DISCH_CYCLES = jgp_pkg::DISCHARGE_CYCLES
) (
   // clock and standby power reset
   input wire logic clk,
   input wire logic srst,
   // host i/o cycle
   input wire logic [15:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   output logic [7:0] io_rdata,
   output logic io_rd_hit,
   // configuration byte access
   input wire logic [7:0] cfg_index,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_wr,
   output logic [7:0] cfg_rdata,
   // timing pins: input is the pad comparator at two thirds reference
   input wire logic [N_AXES-1:0] rc_timing_pins_in,
   output logic [N_AXES-1:0] rc_timing_pins_out,
   output logic [N_AXES-1:0] rc_timing_pins_oe,
   // buttons
   input wire logic stick1_button1,
   input wire logic stick1_button2,
   input wire logic stick2_button1,
   input wire logic stick2_button2,
   // axis timer outputs
   output logic [N_AXES-1:0] axis_timer_outputs
);
   logic [7:0] base_hi_ff;
   logic [7:0] base_lo_ff;
   logic [7:0] pwr_ctl_ff;
   logic activate_ff;
   logic wr_hit_ff;
   logic port_hit;
   logic wr_hit;
   logic axis_trigger;
   logic [7:0] live_status;
   logic [7:0] nxt_cfg_rdata;

   // address decode, blocked while inactive
   assign port_hit = activate_ff && (io_addr == ({base_hi_ff, base_lo_ff} + jgp_pkg::STATUS_OFFSET));
   assign wr_hit = io_wr && port_hit;
   assign io_rd_hit = io_rd && port_hit;

   // write strobe tracking for trailing edge
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_hit_ff <= 1'b0;
      end else if (wr_hit) begin
         wr_hit_ff <= 1'b1;
      end else if (!io_wr) begin
         wr_hit_ff <= 1'b0;
      end
   end

   // one pulse when a decoded write strobe goes inactive
   assign axis_trigger = wr_hit_ff && !io_wr;

   // one timer per axis
   genvar gi;
   generate
      for (gi = 0; gi < N_AXES; gi++) begin : g_axis
         jgp_axis_timer #(
            .DISCH_CYCLES(DISCH_CYCLES)
         ) u_axis (
            .clk(clk),
            .srst(srst),
            .trigger(axis_trigger),
            .threshold_hit(rc_timing_pins_in[gi]),
            .axis_bit(axis_timer_outputs[gi]),
            .pin_out(rc_timing_pins_out[gi]),
            .pin_oe(rc_timing_pins_oe[gi])
         );
      end
   endgenerate

   // live status byte
   always_comb begin
      live_status = jgp_pkg::STATUS_RESET;
      live_status[jgp_pkg::BIT_S1X] = axis_timer_outputs[0];
      live_status[jgp_pkg::BIT_S1Y] = axis_timer_outputs[1];
      live_status[jgp_pkg::BIT_S2X] = axis_timer_outputs[2];
      live_status[jgp_pkg::BIT_S2Y] = axis_timer_outputs[3];
      live_status[jgp_pkg::BIT_S1B1] = stick1_button1;
      live_status[jgp_pkg::BIT_S1B2] = stick1_button2;
      live_status[jgp_pkg::BIT_S2B1] = stick2_button1;
      live_status[jgp_pkg::BIT_S2B2] = stick2_button2;
   end

   // read data, captured during a decoded read only
   always_ff @(posedge clk) begin
      if (srst) begin
         io_rdata <= jgp_pkg::STATUS_RESET;
      end else if (io_rd_hit) begin
         io_rdata <= live_status;
      end
   end

   // base address bytes
   always_ff @(posedge clk) begin
      if (srst) begin
         base_hi_ff <= jgp_pkg::BASE_HI_RESET;
         base_lo_ff <= jgp_pkg::BASE_LO_RESET;
      end else if (cfg_wr && cfg_index == jgp_pkg::CFG_BASE_HI_IDX) begin
         base_hi_ff <= cfg_wdata;
      end else if (cfg_wr && cfg_index == jgp_pkg::CFG_BASE_LO_IDX) begin
         base_lo_ff <= cfg_wdata;
      end
   end

   // activate bit, written from either register
   always_ff @(posedge clk) begin
      if (srst) begin
         activate_ff <= jgp_pkg::ACTIVATE_RESET;
      end else if (cfg_wr && cfg_index == jgp_pkg::CFG_ACTIVATE_IDX) begin
         activate_ff <= cfg_wdata[jgp_pkg::ACTIVATE_BIT];
      end else if (cfg_wr && cfg_index == jgp_pkg::CFG_PWR_CTL_IDX) begin
         activate_ff <= cfg_wdata[jgp_pkg::PWR_GAME_BIT];
      end
   end

   // other power control bits are plain storage
   always_ff @(posedge clk) begin
      if (srst) begin
         pwr_ctl_ff <= jgp_pkg::PWR_CTL_RESET;
      end else if (cfg_wr && cfg_index == jgp_pkg::CFG_PWR_CTL_IDX) begin
         pwr_ctl_ff <= cfg_wdata;
      end
   end

   // configuration readback
   always_comb begin
      nxt_cfg_rdata = 8'h00;
      unique case (cfg_index)
         jgp_pkg::CFG_BASE_HI_IDX: nxt_cfg_rdata = base_hi_ff;
         jgp_pkg::CFG_BASE_LO_IDX: nxt_cfg_rdata = base_lo_ff;
         jgp_pkg::CFG_ACTIVATE_IDX: nxt_cfg_rdata[jgp_pkg::ACTIVATE_BIT] = activate_ff;
         jgp_pkg::CFG_PWR_CTL_IDX: begin
            nxt_cfg_rdata = pwr_ctl_ff;
            nxt_cfg_rdata[jgp_pkg::PWR_GAME_BIT] = activate_ff;
         end
         default: nxt_cfg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_rdata <= 8'h00;
      end else begin
         cfg_rdata <= nxt_cfg_rdata;
      end
   end

   sequence s_wr_end;
      wr_hit_ff && !io_wr;
   endsequence

   property p_trailing_trigger;
      @(posedge clk) disable iff (srst)
      s_wr_end |-> axis_trigger ##1 (axis_timer_outputs == {N_AXES{1'b1}});
   endproperty
   a_trailing_trigger: assert property (p_trailing_trigger) else $error("no restart at write end");

   property p_no_trigger_mid_write;
      @(posedge clk) disable iff (srst)
      wr_hit ##1 io_wr |-> !axis_trigger;
   endproperty
   a_no_trigger_mid_write: assert property (p_no_trigger_mid_write) else $error("restart while strobe active");

   property p_inactive_ignored;
      @(posedge clk) disable iff (srst)
      (!activate_ff) [*2] |-> !axis_trigger && !io_rd_hit;
   endproperty
   a_inactive_ignored: assert property (p_inactive_ignored) else $error("decode while inactive");

   property p_read_live;
      @(posedge clk) disable iff (srst)
      io_rd_hit |=> io_rdata == $past(live_status);
   endproperty
   a_read_live: assert property (p_read_live) else $error("read data not live state");

   property p_write_keeps_data;
      @(posedge clk) disable iff (srst)
      wr_hit && !io_rd_hit |=> $stable(io_rdata);
   endproperty
   a_write_keeps_data: assert property (p_write_keeps_data) else $error("write changed read data");

   property p_mirror_pwr;
      @(posedge clk) disable iff (srst)
      cfg_wr && cfg_index == jgp_pkg::CFG_PWR_CTL_IDX
         |=> activate_ff == $past(cfg_wdata[jgp_pkg::PWR_GAME_BIT]);
   endproperty
   a_mirror_pwr: assert property (p_mirror_pwr) else $error("power bit did not set activate");

   property p_base_hi;
      @(posedge clk) disable iff (srst)
      cfg_wr && cfg_index == jgp_pkg::CFG_BASE_HI_IDX |=> base_hi_ff == $past(cfg_wdata);
   endproperty
   a_base_hi: assert property (p_base_hi) else $error("high base byte not stored");

   property p_base_lo;
      @(posedge clk) disable iff (srst)
      cfg_wr && cfg_index == jgp_pkg::CFG_BASE_LO_IDX |=> base_lo_ff == $past(cfg_wdata);
   endproperty
   a_base_lo: assert property (p_base_lo) else $error("low base byte not stored");

   property p_mirror_act;
      @(posedge clk) disable iff (srst)
      cfg_wr && cfg_index == jgp_pkg::CFG_ACTIVATE_IDX
         |=> activate_ff == $past(cfg_wdata[jgp_pkg::ACTIVATE_BIT]);
   endproperty
   a_mirror_act: assert property (p_mirror_act) else $error("activate write not taken");

   property p_pwr_shadow;
      @(posedge clk) disable iff (srst)
      cfg_index == jgp_pkg::CFG_PWR_CTL_IDX
         |=> cfg_rdata[jgp_pkg::PWR_GAME_BIT] == $past(activate_ff);
   endproperty
   a_pwr_shadow: assert property (p_pwr_shadow) else $error("power bit lost activate");

   property p_ign_rd;
      @(posedge clk) disable iff (srst)
      io_rd && !io_rd_hit |=> $stable(io_rdata);
   endproperty
   a_ign_rd: assert property (p_ign_rd) else $error("ignored read changed data");

   property p_reset_clears;
      @(posedge clk)
      srst |=> io_rdata == jgp_pkg::STATUS_RESET && axis_timer_outputs == '0
         && (&rc_timing_pins_oe);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left state behind");
endmodule : jgp_game_port
`default_nettype wire

// File: jgp_stick_model.sv
`timescale 1ns/1ns
`default_nettype none
module jgp_stick_model #(
   parameter int STEP = 10
) (
   // clock
   input wire logic clk,
   // pin grounded by the port
   input wire logic [3:0] pin_oe,
   // comparator level per axis
   output logic [3:0] pin_level
);
   logic [7:0] chg_ff [4];
   // capacitor charge time, axis i slower by STEP per index
   always_ff @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe[i]) begin
            chg_ff[i] <= 8'h00;
         end else if (chg_ff[i] != 8'hFF) begin
            chg_ff[i] <= chg_ff[i] + 8'h01;
         end
      end
   end
   // comparator trips once charged, drops while grounded
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_level[i] = !pin_oe[i] && (int'(chg_ff[i]) >= STEP * (i + 1));
      end
   end
endmodule : jgp_stick_model
`default_nettype wire

// File: dual_joystick_game_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dual_joystick_game_port_bench;
   // stimulus and observed signals
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] io_addr = 16'h0000;
   logic io_rd = 1'b0;
   logic io_wr = 1'b0;
   logic [7:0] cfg_index = 8'h00;
   logic [7:0] cfg_wdata = 8'h00;
   logic cfg_wr = 1'b0;
   logic [3:0] btn = 4'h0;
   logic [7:0] io_rdata;
   logic [7:0] cfg_rdata;
   logic [7:0] d;
   logic [7:0] idxs [4] = '{8'h60, 8'h61, 8'h30, 8'h22};
   logic h;
   logic io_rd_hit;
   logic [3:0] lvl;
   logic [3:0] pout;
   logic [3:0] oe;
   logic [3:0] axis;
   int failures = 0;
   int cmp_count = 0;
   int t [4];
   int cyc;

   // 50 MHz clock
   always #10 clk = ~clk;

   jgp_game_port #(.N_AXES(4), .DISCH_CYCLES(2)) jgp_game_port_inst (
      .clk(clk), .srst(srst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
      .io_rdata(io_rdata), .io_rd_hit(io_rd_hit), .cfg_index(cfg_index),
      .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata),
      .rc_timing_pins_in(lvl), .rc_timing_pins_out(pout), .rc_timing_pins_oe(oe),
      .stick1_button1(btn[0]), .stick1_button2(btn[1]), .stick2_button1(btn[2]),
      .stick2_button2(btn[3]), .axis_timer_outputs(axis));

   jgp_stick_model #(.STEP(10)) jgp_stick_model_inst (.clk(clk), .pin_oe(oe), .pin_level(lvl));

   // end of run and verdict
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // byte compare
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // configuration write and read
   task automatic cfg_put(input logic [7:0] idx, input logic [7:0] val);
      @(posedge clk);
      cfg_index <= idx;
      cfg_wdata <= val;
      cfg_wr <= 1'b1;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask : cfg_put

   task automatic cfg_get(input logic [7:0] idx, output logic [7:0] val);
      @(posedge clk);
      cfg_index <= idx;
      @(posedge clk);
      #1 val = cfg_rdata;
   endtask : cfg_get

   // host i/o read and write cycles
   task automatic io_get(input logic [15:0] a, output logic hit, output logic [7:0] val);
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      #1 hit = io_rd_hit;
      @(posedge clk);
      io_rd <= 1'b0;
      #1 val = io_rdata;
   endtask : io_get

   task automatic io_put(input logic [15:0] a, input int hold);
      @(posedge clk);
      io_addr <= a;
      io_wr <= 1'b1;
      repeat (hold) @(posedge clk);
      io_wr <= 1'b0;
   endtask : io_put

   // record the cycle at which each axis bit drops
   task automatic watch;
      t = '{default: 0};
      cyc = 0;
      while (axis !== 4'h0 && cyc < 300) begin
         @(posedge clk);
         #1 cyc++;
         for (int i = 0; i < 4; i++) if (axis[i] === 1'b0 && t[i] == 0) t[i] = cyc;
      end
   endtask : watch

   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      stop_test();
   end

   // test sequence
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      #1 chk({oe, axis}, 8'hF0);
      for (int i = 0; i < 4; i++) begin
         cfg_get(idxs[i], d);
         chk(d, 8'h00);
      end
      io_get(16'h0000, h, d);
      chk({7'h00, h}, 8'h00);
      chk(d, 8'h00);
      cfg_put(8'h60, 8'h12);
      cfg_put(8'h61, 8'h34);
      cfg_get(8'h60, d);
      chk(d, 8'h12);
      cfg_get(8'h61, d);
      chk(d, 8'h34);
      cfg_put(8'h22, 8'h04);
      cfg_get(8'h30, d);
      chk(d, 8'h01);
      cfg_put(8'h30, 8'h00);
      cfg_get(8'h22, d);
      chk(d, 8'h00);
      io_get(16'h1234, h, d);
      chk({7'h00, h}, 8'h00);
      cfg_put(8'h30, 8'h01);
      cfg_get(8'h22, d);
      chk(d, 8'h04);
      io_get(16'h3412, h, d);
      chk({7'h00, h}, 8'h00);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) btn <= 4'h1 << k;
         io_get(16'h1234, h, d);
         chk({7'h00, h}, 8'h01);
         chk(d, {4'h1 << k, 4'h0});
      end
      @(posedge clk) btn <= 4'hA;
      io_put(16'h1235, 3);
      @(posedge clk);
      #1 chk({4'h0, axis}, 8'h00);
      io_put(16'h1234, 3);
      #1 chk({4'h0, axis}, 8'h00);
      @(posedge clk);
      #1 chk({oe, axis}, 8'hFF);
      cyc = 0;
      while (oe !== 4'h0 && cyc < 8) begin
         @(posedge clk);
         #1 cyc++;
      end
      chk({4'h0, oe}, 8'h00);
      io_get(16'h1234, h, d);
      chk(d, 8'hAF);
      watch();
      for (int i = 1; i < 4; i++) chk(8'(t[i] - t[0]), 8'(10 * i));
      chk({oe, pout}, 8'hF0);
      io_get(16'h1234, h, d);
      chk(d, 8'hA0);
      io_put(16'h1234, 1);
      io_put(16'h1234, 1);
      #1 chk({4'h0, axis}, 8'h0F);
      watch();
      chk({4'h0, axis}, 8'h00);
      cfg_put(8'h22, 8'h00);
      io_put(16'h1234, 2);
      @(posedge clk);
      #1 chk({oe, axis}, 8'hF0);
      // mid-run reset clears the last read byte, timers and configuration
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1 chk(io_rdata, 8'h00);
      chk({oe, axis}, 8'hF0);
      cfg_get(8'h60, d);
      chk(d, 8'h00);
      io_get(16'h1234, h, d);
      chk({7'h00, h}, 8'h00);
      stop_test();
   end
endmodule : dual_joystick_game_port_bench
`default_nettype wire
